//--- core/rail_fault_mask_good_tree_regs.sv
// rail fault mask and output-one good tree register bank, axi4-lite slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
// How it works
// R1: force-on bit holds rail on unless killed
// R2: force-on clear: rail follows its control request
// R3: mask a: aux two, switch a, rails 6..1
// R4: mask b: aux one, term, switches, aux three
// R5: mask bit 1 blocks shutdown from rail fault
// R6: software writes 0 to mask b bit 6
// R7: software writes 1 to mask b bit 5
// R8: tree mask 0 includes rail good in tree
// R9: tree mask 1 excludes rail good from tree
// R10: tree a: aux two, switch a, rails 6..1
// R11: output good when all unmasked members good
// R12: mask b bit 7 reads zero, ignores writes
module rail_fault_mask_good_tree_regs
  import rail_regs_pkg::*;
#(
  parameter logic [7:0] FAULT_A_RST = 8'h00,
  parameter logic [7:0] FAULT_B_RST = 8'h20,
  parameter logic [7:0] TREE_A_RST  = 8'hFF
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RSTN,
  // axi4-lite write address and data
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [ADDR_W-1:0]   AWADDR,
  input  wire logic [2:0]          AWPROT,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [DATA_W-1:0]   WDATA,
  input  wire logic [3:0]          WSTRB,
  // axi4-lite write response
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  // axi4-lite read
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [ADDR_W-1:0]   ARADDR,
  input  wire logic [2:0]          ARPROT,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [DATA_W-1:0]        RDATA,
  output logic [1:0]               RRESP,
  // rail side
  input  wire logic                AUX3_CTRL_REQ,
  input  wire logic [7:0]          RAIL_FAULT_A,
  input  wire logic [FB_RAILS-1:0] RAIL_FAULT_B,
  input  wire logic [7:0]          RAIL_GOOD_A,
  output logic                     AUX_LDO_THREE_EN,
  output logic                     SHUTDOWN_REQ,
  output logic                     GENERAL_OUT_ONE
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // fixed bits of mask b must reset to their documented values
  if (FAULT_B_RST[FB_RO_BIT] != 1'b0 || FAULT_B_RST[FB_RSVD_ZERO] != 1'b0 ||
      FAULT_B_RST[FB_RSVD_ONE] != 1'b1) begin : g_bad_rst
    $error("FAULT_B_RST fixed bits must be 0,0,1 at bits 7,6,5");
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // shared by the write and read paths; low two bits must be zero
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    unique case (a)
      ADDR_FAULT_A:   s = SEL_FAULT_A;
      ADDR_FAULT_B:   s = SEL_FAULT_B;
      ADDR_TREE_A:    s = SEL_TREE_A;
      ADDR_RAIL_CTRL: s = SEL_RAIL_CTRL;
      ADDR_STATUS:    s = SEL_STATUS;
      default:        s = SEL_NONE;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                unused_prot;
  logic [7:0]          mask_a_reg,  mask_a_next;
  logic [7:0]          mask_b_reg,  mask_b_next;
  logic [7:0]          tree_a_reg,  tree_a_next;
  logic [7:0]          ctrl_reg,    ctrl_next;
  logic                aw_have_reg, aw_have_next;
  logic                w_have_reg,  w_have_next;
  logic [ADDR_W-1:0]   waddr_reg,   waddr_next;
  logic [7:0]          wdata_reg,   wdata_next;
  logic                wstrb_reg,   wstrb_next;
  logic                awready_reg, awready_next;
  logic                wready_reg,  wready_next;
  logic                bvalid_reg,  bvalid_next;
  logic [1:0]          bresp_reg,   bresp_next;
  logic                arready_reg, arready_next;
  logic                rvalid_reg,  rvalid_next;
  logic [DATA_W-1:0]   rdata_reg,   rdata_next;
  logic [1:0]          rresp_reg,   rresp_next;
  logic                aux3_reg,    aux3_next;
  logic                shut_reg,    shut_next;
  logic                good1_reg,   good1_next;
  logic [2:0]          wsel;
  logic [2:0]          rsel;

  assign unused_prot = ^{AWPROT, ARPROT, WSTRB[3:1], WDATA[DATA_W-1:8]};

  // ----------------------------------------------------------------------
  // write channel and register file
  // ----------------------------------------------------------------------
  // address and data may arrive in either order; each is held until both
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    mask_a_next  = mask_a_reg;
    mask_b_next  = mask_b_reg;
    tree_a_next  = tree_a_reg;
    ctrl_next    = ctrl_reg;
    wsel         = reg_sel(waddr_reg);
    if (AWVALID && awready_reg) begin
      aw_have_next = 1'b1;
      waddr_next   = AWADDR;
    end
    if (WVALID && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next  = WDATA[7:0];
      wstrb_next  = WSTRB[0];
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // lane 0 carries the whole byte-wide register
      if (wstrb_reg) begin
        unique case (wsel)
          SEL_FAULT_A:   mask_a_next = wdata_reg;              // R3 R5
          SEL_FAULT_B:   mask_b_next = wdata_reg & FB_WMASK;   // R4 R12
          SEL_TREE_A:    tree_a_next = wdata_reg;              // R10
          SEL_RAIL_CTRL: ctrl_next   = wdata_reg & CTRL_WMASK;
          default:       ctrl_next   = ctrl_reg;  // status is read-only
        endcase
      end
    end
    if (bvalid_reg && BREADY) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      mask_a_reg  <= FAULT_A_RST;
      mask_b_reg  <= FAULT_B_RST;
      tree_a_reg  <= TREE_A_RST;
      ctrl_reg    <= CTRL_RST;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      mask_a_reg  <= mask_a_next;
      mask_b_reg  <= mask_b_next;
      tree_a_reg  <= tree_a_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  // data is captured at the address handshake, so it holds while stalled
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rsel         = reg_sel(ARADDR);
    if (ARVALID && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        SEL_FAULT_A:   rdata_next = {24'h0, mask_a_reg};
        SEL_FAULT_B:   rdata_next = {24'h0, mask_b_reg};          // R12
        SEL_TREE_A:    rdata_next = {24'h0, tree_a_reg};
        SEL_RAIL_CTRL: rdata_next = {24'h0, ctrl_reg};
        SEL_STATUS:    rdata_next = {29'h0, good1_reg, shut_reg, aux3_reg};
        default:       rdata_next = 32'h0000_0000;
      endcase
    end else if (rvalid_reg && RREADY) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ----------------------------------------------------------------------
  // rail side: enable override, fault gating, good tree
  // ----------------------------------------------------------------------
  // kill bit low wins over everything; force only acts while kill is high
  always_comb begin
    aux3_next = ctrl_reg[CTRL_KILL_BIT] &&
                (ctrl_reg[CTRL_FORCE_BIT] || AUX3_CTRL_REQ);    // R1 R2
    shut_next = |(RAIL_FAULT_A & ~mask_a_reg) ||
                |(RAIL_FAULT_B & ~mask_b_reg[FB_RAILS-1:0]);   // R3 R4 R5
    // an empty tree reads good: the and-reduction of all ones
    good1_next = &(RAIL_GOOD_A | tree_a_reg);            // R8 R9 R10 R11
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aux3_reg  <= 1'b0;
      shut_reg  <= 1'b0;
      good1_reg <= 1'b0;
    end else begin
      aux3_reg  <= aux3_next;
      shut_reg  <= shut_next;
      good1_reg <= good1_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign AWREADY          = awready_reg;
  assign WREADY           = wready_reg;
  assign BVALID           = bvalid_reg;
  assign BRESP            = bresp_reg;
  assign ARREADY          = arready_reg;
  assign RVALID           = rvalid_reg;
  assign RDATA            = rdata_reg;
  assign RRESP            = rresp_reg;
  assign AUX_LDO_THREE_EN = aux3_reg;
  assign SHUTDOWN_REQ     = shut_reg;
  assign GENERAL_OUT_ONE  = good1_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence force_held;
    ctrl_reg[CTRL_KILL_BIT] && ctrl_reg[CTRL_FORCE_BIT];
  endsequence
  sequence wr_pair_ready;
    aw_have_reg && w_have_reg && !bvalid_reg;
  endsequence

  force_on_a: assert property (force_held |=> AUX_LDO_THREE_EN) // R1
    else $error("forced rail not on");
  kill_off_a: assert property (!ctrl_reg[CTRL_KILL_BIT] |=> // R1
    !AUX_LDO_THREE_EN) else $error("killed rail still on");
  req_follow_a: assert property (ctrl_reg[CTRL_KILL_BIT] && // R2
    !ctrl_reg[CTRL_FORCE_BIT] |=> AUX_LDO_THREE_EN == $past(AUX3_CTRL_REQ))
    else $error("rail does not follow request");
  mask_a_map_a: assert property (RAIL_FAULT_A[7] && !mask_a_reg[7] |=> // R3
    SHUTDOWN_REQ) else $error("unmasked fault a7 ignored");
  mask_b_map_a: assert property (RAIL_FAULT_B[4] && !mask_b_reg[4] |=> // R4
    SHUTDOWN_REQ) else $error("unmasked fault b4 ignored");
  masked_fault_a: assert property ((RAIL_FAULT_A & ~mask_a_reg) == 8'h00 && // R5
    (RAIL_FAULT_B & ~mask_b_reg[FB_RAILS-1:0]) == 5'h00 |=> !SHUTDOWN_REQ)
    else $error("shutdown from masked fault");
  tree_member_a: assert property (!tree_a_reg[6] && !RAIL_GOOD_A[6] |=> // R8
    !GENERAL_OUT_ONE) else $error("member not good but output good");
  // sampled reset: the edge that releases it still loads the reset value
  tree_all_a: assert property (RSTN && &(RAIL_GOOD_A | tree_a_reg) // R9 R11
    |=> GENERAL_OUT_ONE) else $error("all members good but output low");
  rsvd_zero_a: assert property (mask_b_reg[FB_RO_BIT] == 1'b0 && // R12
    RDATA[31:8] == 24'h0) else $error("read-only bits not zero");
  wr_resp_a: assert property (wr_pair_ready ##0 wsel == SEL_FAULT_A &&
    wstrb_reg |=> BVALID && mask_a_reg == $past(wdata_reg)) // R3
    else $error("write not applied with response");

endmodule

//--- core/rail_regs_pkg.sv
// constants shared by the rail fault mask and good tree register bank
package rail_regs_pkg;

  // ----------------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  IDX_FAULT_A   = 8'hA2;
  localparam logic [7:0]  IDX_FAULT_B   = 8'hA3;
  localparam logic [7:0]  IDX_TREE_A    = 8'hA4;
  localparam logic [7:0]  IDX_RAIL_CTRL = 8'hB0;
  localparam logic [7:0]  IDX_STATUS    = 8'hB1;
  localparam logic [11:0] ADDR_FAULT_A  = {2'h0, IDX_FAULT_A, 2'h0};
  localparam logic [11:0] ADDR_FAULT_B  = {2'h0, IDX_FAULT_B, 2'h0};
  localparam logic [11:0] ADDR_TREE_A   = {2'h0, IDX_TREE_A, 2'h0};
  localparam logic [11:0] ADDR_RAIL_CTRL = {2'h0, IDX_RAIL_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------------
  // register select codes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SEL_NONE      = 3'h0;
  localparam logic [2:0]  SEL_FAULT_A   = 3'h1;
  localparam logic [2:0]  SEL_FAULT_B   = 3'h2;
  localparam logic [2:0]  SEL_TREE_A    = 3'h3;
  localparam logic [2:0]  SEL_RAIL_CTRL = 3'h4;
  localparam logic [2:0]  SEL_STATUS    = 3'h5;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int          FB_RO_BIT     = 7;
  localparam int          FB_RSVD_ZERO  = 6;
  localparam int          FB_RSVD_ONE   = 5;
  localparam logic [7:0]  FB_WMASK      = 8'h7F;
  localparam int          FB_RAILS      = 5;
  localparam int          CTRL_FORCE_BIT = 0;
  localparam int          CTRL_KILL_BIT = 1;
  localparam logic [7:0]  CTRL_RST      = 8'h02;
  localparam logic [7:0]  CTRL_WMASK    = 8'h03;
  localparam int          STAT_AUX3_EN  = 0;
  localparam int          STAT_SHUTDOWN = 1;
  localparam int          STAT_GOOD_ONE = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

//--- verification/rail_fault_mask_good_tree_regs_tb.sv
// self-checking bench for the rail fault mask and good tree register bank
`timescale 1ns/1ps
module rail_fault_mask_good_tree_regs_tb;
  import rail_regs_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic              CLK = 1'b0;
  logic              RSTN = 1'b0;
  logic              AWVALID = 1'b0, AWREADY, WVALID = 1'b0, WREADY;
  logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
  logic [DATA_W-1:0] WDATA = '0, RDATA;
  logic [3:0]        WSTRB = 4'h0;
  logic              BVALID, BREADY = 1'b0, ARVALID = 1'b0, ARREADY;
  logic              RVALID, RREADY = 1'b0;
  logic [1:0]        BRESP, RRESP;
  logic              AUX3_CTRL_REQ = 1'b0;
  logic [7:0]        RAIL_FAULT_A = 8'h00, RAIL_GOOD_A = 8'hFF;
  logic [4:0]        RAIL_FAULT_B = 5'h00;
  logic              AUX_LDO_THREE_EN, SHUTDOWN_REQ, GENERAL_OUT_ONE;
  int                errors = 0;
  int                tests_run = 0;

  // protection bits are ignored by the block, so they stay tied
  rail_fault_mask_good_tree_regs DUT (
    .CLK(CLK), .RSTN(RSTN),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .AUX3_CTRL_REQ(AUX3_CTRL_REQ), .RAIL_FAULT_A(RAIL_FAULT_A),
    .RAIL_FAULT_B(RAIL_FAULT_B), .RAIL_GOOD_A(RAIL_GOOD_A),
    .AUX_LDO_THREE_EN(AUX_LDO_THREE_EN), .SHUTDOWN_REQ(SHUTDOWN_REQ),
    .GENERAL_OUT_ONE(GENERAL_OUT_ONE)
  );

  // clock at 10 mhz
  always begin
    #50 CLK = ~CLK;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] resp);
    bit got;
    got = 0;
    AWVALID <= 1'b1;
    AWADDR  <= a;
    WVALID  <= 1'b1;
    WDATA   <= {24'h000000, d};
    WSTRB   <= s;
    BREADY  <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        got = 1;
        BREADY <= 1'b0;
        check(32'(BRESP), 32'(resp), "write response");
      end
    end
    if (!got) check(32'h0, 32'h1, "write never answered");
    @(posedge CLK);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] resp);
    bit got;
    got = 0;
    ARVALID <= 1'b1;
    ARADDR  <= a;
    RREADY  <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        got = 1;
        RREADY <= 1'b0;
        check(RDATA, {24'h000000, d}, "read data");
        check(32'(RRESP), 32'(resp), "read response");
      end
    end
    if (!got) check(32'h0, 32'h1, "read never answered");
    @(posedge CLK);
  endtask

  // outputs follow inputs one cycle late; three edges leave margin
  task automatic outs(input logic en, input logic sd, input logic g);
    repeat (3) @(posedge CLK);
    check(32'({AUX_LDO_THREE_EN, SHUTDOWN_REQ, GENERAL_OUT_ONE}),
          32'({en, sd, g}), "rail outputs");
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLK);
    // reset values and all-masked tree
    rd(ADDR_FAULT_A, 8'h00, RESP_OKAY);
    rd(ADDR_FAULT_B, 8'h20, RESP_OKAY);
    rd(ADDR_TREE_A, 8'hFF, RESP_OKAY);
    rd(ADDR_RAIL_CTRL, 8'h02, RESP_OKAY);
    check(32'(GENERAL_OUT_ONE), 32'h1, "tree all masked");
    // each fault a bit shuts down unless its own mask bit is set
    for (int i = 0; i < 8; i++) begin
      RAIL_FAULT_A <= 8'h01 << i;
      wr(ADDR_FAULT_A, ~(8'h01 << i), 4'h1, RESP_OKAY);
      outs(1'b0, 1'b1, 1'b1);
      rd(ADDR_STATUS, 8'h06, RESP_OKAY);
      wr(ADDR_FAULT_A, 8'h01 << i, 4'h1, RESP_OKAY);
      outs(1'b0, 1'b0, 1'b1);
      rd(ADDR_FAULT_A, 8'h01 << i, RESP_OKAY);
    end
    RAIL_FAULT_A <= 8'h00;
    // each fault b bit shuts down unless masked; every write sets mask b bit 6 to 0 and bit 5 to 1
    for (int i = 0; i < 5; i++) begin
      RAIL_FAULT_B <= 5'h01 << i;
      wr(ADDR_FAULT_B, 8'h20 | (~(8'h01 << i) & 8'h1F), 4'h1, RESP_OKAY);
      outs(1'b0, 1'b1, 1'b1);
      wr(ADDR_FAULT_B, 8'h20 | (8'h01 << i), 4'h1, RESP_OKAY);
      outs(1'b0, 1'b0, 1'b1);
    end
    RAIL_FAULT_B <= 5'h00;
    // top bit of mask b reads back zero
    wr(ADDR_FAULT_B, 8'hBF, 4'h1, RESP_OKAY);
    rd(ADDR_FAULT_B, 8'h3F, RESP_OKAY);
    // each good bit counts only while unmasked
    for (int i = 0; i < 8; i++) begin
      RAIL_GOOD_A <= ~(8'h01 << i);
      wr(ADDR_TREE_A, 8'h00, 4'h1, RESP_OKAY);
      outs(1'b0, 1'b0, 1'b0);
      wr(ADDR_TREE_A, 8'h01 << i, 4'h1, RESP_OKAY);
      outs(1'b0, 1'b0, 1'b1);
      wr(ADDR_TREE_A, ~(8'h01 << i), 4'h1, RESP_OKAY);
      outs(1'b0, 1'b0, 1'b0);
    end
    RAIL_GOOD_A <= 8'hFF;
    wr(ADDR_TREE_A, 8'h00, 4'h1, RESP_OKAY);
    outs(1'b0, 1'b0, 1'b1);
    // aux ldo three: request, force, kill
    AUX3_CTRL_REQ <= 1'b1;
    outs(1'b1, 1'b0, 1'b1);
    AUX3_CTRL_REQ <= 1'b0;
    wr(ADDR_RAIL_CTRL, 8'h03, 4'h1, RESP_OKAY);
    outs(1'b1, 1'b0, 1'b1);
    rd(ADDR_STATUS, 8'h05, RESP_OKAY);
    AUX3_CTRL_REQ <= 1'b1;
    wr(ADDR_RAIL_CTRL, 8'h01, 4'h1, RESP_OKAY);
    outs(1'b0, 1'b0, 1'b1);
    // refused and ignored accesses leave state alone
    wr(ADDR_TREE_A, 8'h5A, 4'h0, RESP_OKAY);
    rd(ADDR_TREE_A, 8'h00, RESP_OKAY);
    wr(12'h2A0, 8'h5A, 4'h1, RESP_SLVERR);
    rd(12'h2A0, 8'h00, RESP_SLVERR);
    wr(ADDR_STATUS, 8'hFF, 4'h1, RESP_OKAY);
    rd(ADDR_STATUS, 8'h04, RESP_OKAY);
    stop_test();
  end

  // watchdog well beyond the expected run of about five hundred cycles
  initial begin
    #(100 * 20000);
    errors++;
    stop_test();
  end
endmodule
